// ==== hdl/bma_averager.sv ====
// Block averager that posts a saturated 16-bit mean of N samples.
`timescale 1ns/10ps
`default_nettype none
module bma_averager #(
   parameter int N  = 128,  // Samples per window.
   parameter int IW = 18    // Signed input width.
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   input  wire logic                 in_valid_i,
   input  wire logic signed [IW-1:0] in_data_i,
   output logic signed [15:0]        result_o,
   output logic                      update_o
);

   // ==========================================================================
   // Sizing.
   localparam int SW = IW + $clog2(N) + 1;
   localparam int CW = $clog2(N) + 1;
   localparam logic signed [SW-1:0] N_S  = SW'(N);
   localparam logic signed [SW-1:0] MAXV = SW'(32767);
   localparam logic signed [SW-1:0] MINV = -SW'(32768);

   logic signed [SW-1:0] sum;     // Running window sum.
   logic [CW-1:0]        count;   // Samples taken in this window.
   logic signed [SW-1:0] next_sum;
   logic signed [SW-1:0] mean;

   // Sum including the incoming sample, and the window mean.
   always_comb begin
      next_sum = sum + SW'(in_data_i);
      mean     = next_sum / N_S;
   end

   // Window bookkeeping and result posting; the result changes in one edge.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sum      <= '0;
         count    <= '0;
         result_o <= 16'sh0000;
         update_o <= 1'b0;
      end else if (ce_i) begin
         update_o <= 1'b0;
         if (in_valid_i) begin
            if (count == CW'(N - 1)) begin
               // Clamp so that out-of-range means report the extreme codes.
               if (mean > MAXV) begin
                  result_o <= 16'sh7fff;
               end else if (mean < MINV) begin
                  result_o <= 16'sh8000;
               end else begin
                  result_o <= mean[15:0];
               end
               update_o <= 1'b1;
               sum      <= '0;
               count    <= '0;
            end else begin
               sum   <= next_sum;
               count <= count + CW'(1);
            end
         end
      end
   end

endmodule : bma_averager
`default_nettype wire

// ==== hdl/bma_pkg.sv ====
// Package of constants and types for the battery measurement accumulator.
package bma_pkg;

   // ==========================================================================
   // Word addresses of the memory-mapped results and the configuration word.
   localparam logic [15:0] ADDR_CELL_VOLTAGE_RESULT = 16'h6003;
   localparam logic [15:0] ADDR_CURRENT_RESULT      = 16'h6004;
   localparam logic [15:0] ADDR_TEMPERATURE_RESULT  = 16'h6005;
   localparam logic [15:0] ADDR_CHARGE_ACC_HIGH     = 16'h6006;
   localparam logic [15:0] ADDR_CHARGE_ACC_MID      = 16'h6007;
   localparam logic [15:0] ADDR_CHARGE_ACC_LOW      = 16'h6008;
   localparam logic [15:0] ADDR_LONG_AVERAGE        = 16'h6009;
   localparam logic [15:0] ADDR_CONVERTER_CONFIG    = 16'h600a;

   // ==========================================================================
   // Timing: clock period, sample period and derived cycle count.
   localparam int CLK_PERIOD_NS    = 25;
   localparam int SAMPLE_PERIOD_NS = 687000;
   localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

   // ==========================================================================
   // Sample counts for averaging and cadence.
   localparam int CUR_AVG_N   = 128;   // Current result window (about 88 ms).
   localparam int LONG_AVG_N  = 4096;  // Long average window (about 2.8 s).
   localparam int VOLT_AVG_N  = 5;     // Voltage window (about 3.4 ms).
   localparam int TEMP_AVG_N  = 32;    // Temperature window (about 220 ms).
   localparam int TEMP_EVERY  = 10;    // Sample periods per temperature sample.

   // ==========================================================================
   // Accumulator layout and per-sample weights in units of 2^-32 of the main LSB.
   localparam int ACC_W        = 48;   // 16 integer plus 32 fractional bits.
   localparam int ACC_XW       = 50;   // Guard width for saturation.
   localparam int FRAC_W       = 32;
   localparam int SAMPLE_SHIFT = 11;   // Weight of one current code per sample.
   localparam int BIAS_SHIFT   = 7;    // Weight of one bias code per sample.
   localparam logic signed [17:0] BLANK_CODES = 18'sh00004; // 62.5 uV in current codes.

   // ==========================================================================
   // Offset filter: fractional bits and smoothing shift.
   localparam int OFF_FRAC  = 4;
   localparam int OFF_SHIFT = 4;

   // ==========================================================================
   // Configuration word layout and reset value.
   typedef struct packed {
      logic [7:0] accumulation_bias;    // Signed bias, bits 15:8.
      logic [4:0] protect_fields;       // Protector thresholds, bits 7:3.
      logic [1:0] reserved;             // Reads as zero, bits 2:1.
      logic       offset_blank_enable;  // Bit 0.
   } bma_cfg_t;
   localparam logic [15:0] CFG_RESET = 16'h0000;

   // ==========================================================================
   // Converter channels and sequencer states.
   typedef enum logic [1:0] {
      CH_CURRENT = 2'h0,
      CH_ZERO    = 2'h1,
      CH_VOLTAGE = 2'h2,
      CH_TEMP    = 2'h3
   } bma_chan_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CUR  = 3'h1,
      ST_ZERO = 3'h3,
      ST_VOLT = 3'h2,
      ST_TEMP = 3'h6
   } bma_state_t;

endpackage : bma_pkg

// ==== hdl/bma_top.sv ====
// Measurement sequencer, result registers and charge accumulator.
`timescale 1ns/10ps
`default_nettype none
module bma_top
   import bma_pkg::*;
#(
   parameter int SAMPLE_CYC = SAMPLE_CYCLES  // Clock cycles per sample period.
) (
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESET_I,
   input  wire logic        CE_I,
   output logic             CONV_REQ_O,
   output logic [1:0]       CONV_CH_O,
   input  wire logic        CONV_VALID_I,
   input  wire logic [15:0] CONV_DATA_I,
   input  wire logic [15:0] MEM_ADDR_I,
   input  wire logic        MEM_RD_I,
   input  wire logic        MEM_WR_I,
   input  wire logic [15:0] MEM_WDATA_I,
   output logic [15:0]      MEM_RDATA_O
);

   // ==========================================================================
   // Declarations.
   localparam int TW = $clog2(SAMPLE_CYC) + 1;
   localparam logic signed [ACC_XW-1:0] ACC_MAX = ACC_XW'({1'b0, {(ACC_W-1){1'b1}}});
   localparam logic signed [ACC_XW-1:0] ACC_MIN = -ACC_MAX - ACC_XW'(1);

   bma_state_t              state;        // Sequencer state.
   logic [TW-1:0]           tick_cnt;     // Sample period timer.
   logic                    tick;         // One-cycle start of a period.
   logic [3:0]              temp_div;     // Periods since last temperature sample.
   logic                    temp_due;     // This period also samples temperature.
   bma_cfg_t                cfg;          // Converter configuration word.
   logic signed [19:0]      off_acc;      // Offset estimate with fraction.
   logic signed [20:0]      off_err;      // Filter error term.
   logic signed [17:0]      cur_corr;     // Offset-corrected current code.
   logic                    cur_step;     // A current sample arrives.
   logic                    blanked;      // Sample is dropped by blanking.
   logic signed [ACC_XW-1:0] acc_delta;   // Per-sample accumulator step.
   logic signed [ACC_XW-1:0] acc_sum;     // Unsaturated new accumulator.
   logic signed [ACC_W-1:0] acc;          // Charge accumulator, 16.32 format.
   logic signed [15:0]      cur_res;      // Current result.
   logic signed [15:0]      long_res;     // Long average current result.
   logic signed [15:0]      volt_res;     // Voltage result.
   logic signed [15:0]      temp_res;     // Temperature result.
   logic                    cur_upd;      // Current result posted.
   logic                    acc_wr;       // Software loads the accumulator.
   logic                    cfg_wr;       // Software writes the configuration.

   // ==========================================================================
   // Sample period timer; the count is long, so it is a parameter.
   // fixed period
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         tick_cnt <= '0;
      end else if (CE_I) begin
         if (tick) begin
            tick_cnt <= '0;
         end else begin
            tick_cnt <= tick_cnt + TW'(1);
         end
      end
   end
   assign tick = (tick_cnt == TW'(SAMPLE_CYC - 1));

   // Temperature cadence counter; wraps every ten periods.
   // tenth period
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         temp_div <= 4'h0;
      end else if (CE_I && tick) begin
         if (temp_div == 4'(TEMP_EVERY - 1)) begin
            temp_div <= 4'h0;
         end else begin
            temp_div <= temp_div + 4'h1;
         end
      end
   end
   assign temp_due = (temp_div == 4'h0);

   // ==========================================================================
   // Sequencer: current, offset zero, voltage, then temperature when due.
   // A period tick during a slow conversion is dropped rather than queued.
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         state <= ST_IDLE;
      end else if (CE_I) begin
         case (state)
            ST_IDLE: begin
               if (tick) begin
                  state <= ST_CUR;
               end
            end
            ST_CUR: begin
               if (CONV_VALID_I) begin
                  state <= ST_ZERO;
               end
            end
            ST_ZERO: begin
               if (CONV_VALID_I) begin
                  state <= ST_VOLT;
               end
            end
            ST_VOLT: begin
               if (CONV_VALID_I) begin
                  state <= temp_due ? ST_TEMP : ST_IDLE;
               end
            end
            ST_TEMP: begin
               if (CONV_VALID_I) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Conversion request: one pulse on entry to each converting state.
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         CONV_REQ_O <= 1'b0;
         CONV_CH_O  <= CH_CURRENT;
      end else if (CE_I) begin
         CONV_REQ_O <= 1'b0;
         if (state == ST_IDLE && tick) begin
            CONV_REQ_O <= 1'b1;
            CONV_CH_O  <= CH_CURRENT;
         end else if (state == ST_CUR && CONV_VALID_I) begin
            CONV_REQ_O <= 1'b1;
            CONV_CH_O  <= CH_ZERO;
         end else if (state == ST_ZERO && CONV_VALID_I) begin
            CONV_REQ_O <= 1'b1;
            CONV_CH_O  <= CH_VOLTAGE;
         end else if (state == ST_VOLT && CONV_VALID_I && temp_due) begin
            CONV_REQ_O <= 1'b1;
            CONV_CH_O  <= CH_TEMP;
         end
      end
   end

   // ==========================================================================
   // Offset cancellation from the shorted-input conversion, smoothed.
   // offset filter
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         off_acc <= 20'sh00000;
      end else if (CE_I && state == ST_ZERO && CONV_VALID_I) begin
         off_acc <= off_acc + 20'(off_err >>> OFF_SHIFT);
      end
   end

   // Correction and accumulator step. Data is positive-input minus negative-input.
   always_comb begin
      off_err   = 21'($signed({CONV_DATA_I, 4'h0})) - 21'(off_acc);
      // signed current
      // The offset estimate is signed; a bare part-select would zero-extend it.
      cur_corr  = 18'($signed(CONV_DATA_I)) - 18'($signed(off_acc[19:OFF_FRAC]));
      cur_step  = CE_I && (state == ST_CUR) && CONV_VALID_I;
      blanked   = cfg.offset_blank_enable && (cur_corr > 18'sh00000) &&
                  (cur_corr < BLANK_CODES);
      acc_delta = (ACC_XW'($signed(cfg.accumulation_bias)) <<< BIAS_SHIFT);
      if (!blanked) begin
         acc_delta = acc_delta + (ACC_XW'(cur_corr) <<< SAMPLE_SHIFT);
      end
      acc_sum   = ACC_XW'(acc) + acc_delta;
   end

   // ==========================================================================
   // Charge accumulator; a software load wins over a sample in the same cycle.
   assign acc_wr = CE_I && MEM_WR_I && (MEM_ADDR_I == ADDR_CHARGE_ACC_HIGH);
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         acc <= '0;
      end else if (acc_wr) begin
         acc <= {MEM_WDATA_I, {FRAC_W{1'b0}}};
      end else if (cur_step) begin
         if (acc_sum > ACC_MAX) begin
            acc <= ACC_MAX[ACC_W-1:0];
         end else if (acc_sum < ACC_MIN) begin
            acc <= ACC_MIN[ACC_W-1:0];
         end else begin
            acc <= acc_sum[ACC_W-1:0];
         end
      end
   end

   // ==========================================================================
   // Configuration word; reserved bits are not stored.
   assign cfg_wr = CE_I && MEM_WR_I && (MEM_ADDR_I == ADDR_CONVERTER_CONFIG);
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         cfg <= bma_cfg_t'(CFG_RESET);
      end else if (cfg_wr) begin
         cfg <= bma_cfg_t'(MEM_WDATA_I & 16'hfff9);
      end
   end

   // ==========================================================================
   // Averagers. Each posts its word in a single edge.
   // 128-sample mean
   bma_averager #(.N(CUR_AVG_N), .IW(18)) u_cur_avg (
      .clk_i      (CLK_SYS_I),
      .rst_i      (RESET_I),
      .ce_i       (CE_I),
      .in_valid_i (cur_step),
      .in_data_i  (cur_corr),
      .result_o   (cur_res),
      .update_o   (cur_upd)
   );

   bma_averager #(.N(LONG_AVG_N), .IW(18)) u_long_avg (
      .clk_i      (CLK_SYS_I),
      .rst_i      (RESET_I),
      .ce_i       (CE_I),
      .in_valid_i (cur_step),
      .in_data_i  (cur_corr),
      .result_o   (long_res),
      .update_o   ()
   );

   bma_averager #(.N(VOLT_AVG_N), .IW(17)) u_volt_avg (
      .clk_i      (CLK_SYS_I),
      .rst_i      (RESET_I),
      .ce_i       (CE_I),
      .in_valid_i (CE_I && state == ST_VOLT && CONV_VALID_I),
      .in_data_i  ($signed({1'b0, CONV_DATA_I})),
      .result_o   (volt_res),
      .update_o   ()
   );

   bma_averager #(.N(TEMP_AVG_N), .IW(16)) u_temp_avg (
      .clk_i      (CLK_SYS_I),
      .rst_i      (RESET_I),
      .ce_i       (CE_I),
      .in_valid_i (CE_I && state == ST_TEMP && CONV_VALID_I),
      .in_data_i  ($signed(CONV_DATA_I)),
      .result_o   (temp_res),
      .update_o   ()
   );

   // ==========================================================================
   // Read port: registered, one cycle after the read strobe; unmapped reads 0.
   // Coherence across the three accumulator words is left to software.
   // result map
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         MEM_RDATA_O <= 16'h0000;
      end else if (CE_I && MEM_RD_I) begin
         case (MEM_ADDR_I)
            ADDR_CELL_VOLTAGE_RESULT: MEM_RDATA_O <= volt_res;
            ADDR_CURRENT_RESULT:      MEM_RDATA_O <= cur_res;
            ADDR_TEMPERATURE_RESULT:  MEM_RDATA_O <= temp_res;
            ADDR_CHARGE_ACC_HIGH:     MEM_RDATA_O <= acc[47:32];
            ADDR_CHARGE_ACC_MID:      MEM_RDATA_O <= acc[31:16];
            ADDR_CHARGE_ACC_LOW:      MEM_RDATA_O <= acc[15:0];
            ADDR_LONG_AVERAGE:        MEM_RDATA_O <= long_res;
            ADDR_CONVERTER_CONFIG:    MEM_RDATA_O <= cfg;
            default:                  MEM_RDATA_O <= 16'h0000;
         endcase
      end
   end

   // ==========================================================================
   // Assertions.
   property p_load_clears;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      acc_wr |=> (acc[47:32] == $past(MEM_WDATA_I)) && (acc[31:0] == 32'h0);
   endproperty
   a_load_clears: assert property (p_load_clears) else $error("load wrong");

   property p_req_after_tick;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (CE_I && tick && state == ST_IDLE) |=> CONV_REQ_O && CONV_CH_O == CH_CURRENT;
   endproperty
   a_req_after_tick: assert property (p_req_after_tick) else $error("no request");

   // The request shows one edge after the decision, and a tick on that same edge
   // may already have moved the cadence counter, so check the decision's value.
   property p_temp_cadence;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (CONV_REQ_O && CONV_CH_O == CH_TEMP) |-> $past(temp_due);
   endproperty
   a_temp_cadence: assert property (p_temp_cadence) else $error("temp cadence");

   property p_blank_bias_only;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (cur_step && !acc_wr && blanked && cfg.accumulation_bias == 8'h00 &&
       cfg.offset_blank_enable) |=> acc == $past(acc);
   endproperty
   a_blank_bias_only: assert property (p_blank_bias_only) else $error("blank");

   property p_sat_high;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (cur_step && !acc_wr && ACC_XW'(acc) == ACC_MAX && acc_delta >= 0)
      |=> ACC_XW'(acc) == ACC_MAX;
   endproperty
   a_sat_high: assert property (p_sat_high) else $error("acc wrapped");

   property p_unmapped_zero;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (CE_I && MEM_RD_I && (MEM_ADDR_I < ADDR_CELL_VOLTAGE_RESULT ||
       MEM_ADDR_I > ADDR_CONVERTER_CONFIG)) |=> MEM_RDATA_O == 16'h0000;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped");

   property p_reserved_zero;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (CE_I && MEM_RD_I && MEM_ADDR_I == ADDR_CONVERTER_CONFIG)
      |=> MEM_RDATA_O[2:1] == 2'b00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved");

   property p_cur_held;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (!cur_upd) |-> $stable(cur_res);
   endproperty
   a_cur_held: assert property (p_cur_held) else $error("current moved");

   property p_bias_add;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
      (cur_step && !acc_wr && !blanked && cur_corr == 18'sh0 &&
       ACC_XW'(acc) < ACC_MAX - 50'sd65536 && ACC_XW'(acc) > ACC_MIN + 50'sd65536)
      |=> ACC_XW'(acc) == ACC_XW'($past(acc)) +
          (ACC_XW'($signed($past(cfg.accumulation_bias))) <<< BIAS_SHIFT);
   endproperty
   a_bias_add: assert property (p_bias_add) else $error("bias add");

endmodule : bma_top
`default_nettype wire

// ==== verif/bma_conv_model.sv ====
// Converter and temperature sensor stand-in that answers conversion requests.
`timescale 1ns/10ps
`default_nettype none
module bma_conv_model
   import bma_pkg::*;
(
   input  wire logic        clk_i,   // System clock.
   input  wire logic        go_i,    // High lets a waiting request be answered.
   input  wire logic [63:0] val_i,   // Data per channel: temp, volt, zero, current.
   input  wire logic        req_i,   // Conversion request pulse.
   input  wire logic [1:0]  ch_i,    // Channel of the request.
   output logic             valid_o, // One-cycle answer strobe.
   output logic [15:0]      data_o   // Answer data.
);
   logic        pend = 1'b0;      // A request waits for its answer.
   logic [1:0]  ch   = 2'h0;      // Channel of the waiting request.
   logic        vld  = 1'b0;      // Answer strobe register.
   logic [15:0] dat  = 16'h0000;  // Answer data register.
   assign valid_o = vld;
   assign data_o  = dat;
   // =========================================================================
   // Answer each request once; holding go low makes the answer slow.
   // Outside an answer the data line flips every cycle, so stale data is never
   // mistaken for a fresh result.
   always @(posedge clk_i) begin
      vld <= 1'b0;
      dat <= ~dat;
      if (req_i) begin
         pend <= 1'b1;
         ch <= ch_i;
      end else if (pend && go_i) begin
         pend <= 1'b0;
         vld <= 1'b1;
         dat <= val_i[{ch, 4'h0} +: 16];
      end
   end
endmodule : bma_conv_model
`default_nettype wire

// ==== verif/test_battery_measurement_accumulator.sv ====
// Self-checking bench for the battery measurement accumulator.
`timescale 1ns/10ps
`default_nettype none
module test_battery_measurement_accumulator
   import bma_pkg::*;
;
   typedef struct packed {
      logic [15:0] cfg;
      logic [15:0] cur;
      logic [15:0] init;
      logic [15:0] k;
      logic [47:0] ex;
   } bma_case_t;
   // Accumulator cases: config, current code, loaded word, samples, result.
   bma_case_t   cs [9] = '{
      '{16'h0000, 16'h0001, 16'h0000, 16'd4, 48'h0000_0000_2000},
      '{16'h0100, 16'h0000, 16'h0000, 16'd4, 48'h0000_0000_0200},
      '{16'hff00, 16'h0000, 16'h0000, 16'd2, 48'hffff_ffff_ff00},
      '{16'h0001, 16'h0003, 16'h0000, 16'd3, 48'h0000_0000_0000},
      '{16'h0001, 16'h0004, 16'h0000, 16'd1, 48'h0000_0000_2000},
      '{16'h0001, 16'hffff, 16'h0000, 16'd2, 48'hffff_ffff_f000},
      '{16'h0000, 16'h7fff, 16'h7fff, 16'd70, 48'h7fff_ffff_ffff},
      '{16'h0000, 16'h0000, 16'h1234, 16'd0, 48'h1234_0000_0000},
      '{16'h0000, 16'h8000, 16'h8000, 16'd1, 48'h8000_0000_0000}};
   logic        clk = 1'b0;      // 40 MHz system clock.
   logic        rst = 1'b1;      // Reset, held at start.
   logic        ce = 1'b1;       // Clock enable; low freezes the block.
   logic        go = 1'b0;       // Lets the converter answer.
   logic [63:0] val = '0;        // Converter data per channel.
   logic [15:0] addr = '0;       // Register port.
   logic [15:0] wdata = '0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [15:0] rdata, dat;
   logic [1:0]  ch;
   logic        req, vld;
   int          fail_count = 0;  // Mismatches seen.
   int          cmp_count = 0;   // Comparisons made.
   int          ncur = 0;        // Current samples delivered.
   always #12.5 clk = ~clk;
   // A short period that still outlasts a full four-conversion sequence, so no
   // tick is dropped in steady running and every tenth period samples temperature.
   bma_top #(.SAMPLE_CYC(16)) dut_u (.CLK_SYS_I(clk), .RESET_I(rst), .CE_I(ce),
      .CONV_REQ_O(req), .CONV_CH_O(ch), .CONV_VALID_I(vld), .CONV_DATA_I(dat),
      .MEM_ADDR_I(addr), .MEM_RD_I(rd), .MEM_WR_I(wr), .MEM_WDATA_I(wdata),
      .MEM_RDATA_O(rdata));
   bma_conv_model conv_u (.clk_i(clk), .go_i(go), .val_i(val), .req_i(req),
      .ch_i(ch), .valid_o(vld), .data_o(dat));
   // Count answered current conversions.
   always @(posedge clk) if (vld && ch == 2'h0) ncur <= ncur + 1;
   // =========================================================================
   task automatic report_and_stop;
      $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [15:0] got, input logic [15:0] ex);
      cmp_count++;
      if (got !== ex) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, ex);
      end
   endtask : chk
   // One full-word read; data is taken after the edge that accepts it.
   // single-word access
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] ex);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, ex);
   endtask : rd_chk
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // Let the converter deliver k more current samples, then hold it off.
   task automatic run(input int k);
      int tgt;
      int i;
      tgt = ncur + k;
      i = 0;
      @(posedge clk);
      go <= 1'b1;
      while (ncur < tgt && i < 64 * k + 64) begin
         @(posedge clk);
         i++;
      end
      go <= 1'b0;
      if (ncur < tgt) begin
         fail_count++;
         $display("unexpected at %0t: converter sequence stalled", $time);
         report_and_stop();
      end
      repeat (12) @(posedge clk);
   endtask : run
   // =========================================================================
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int a = 16'h6002; a <= 16'h600b; a++) rd_chk(16'(a), 16'h0000); // map
      wr_reg(ADDR_CURRENT_RESULT, 16'hffff);
      rd_chk(ADDR_CURRENT_RESULT, 16'h0000); // read only
      wr_reg(ADDR_CONVERTER_CONFIG, 16'hffff);
      rd_chk(ADDR_CONVERTER_CONFIG, 16'hfff9); // fields
      wr_reg(ADDR_CONVERTER_CONFIG, 16'h0000);
      // Frozen: the write is ignored and the read port keeps its last word.
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(ADDR_CONVERTER_CONFIG, 16'h5501);
      rd_chk(ADDR_CURRENT_RESULT, 16'hfff9); // read port holds
      @(posedge clk);
      ce <= 1'b1;
      rd_chk(ADDR_CONVERTER_CONFIG, 16'h0000); // frozen write lost
      $display("test registers done");
      val <= 64'hfff0_0123_0000_0005;
      run(4100);
      rd_chk(ADDR_CURRENT_RESULT, 16'h0005); // mean current
      rd_chk(ADDR_LONG_AVERAGE, 16'h0005); // long mean
      rd_chk(ADDR_CELL_VOLTAGE_RESULT, 16'h0123); // mean voltage
      rd_chk(ADDR_TEMPERATURE_RESULT, 16'hfff0); // signed temperature
      val <= 64'hfff0_ffff_0000_0005;
      run(12);
      rd_chk(ADDR_CELL_VOLTAGE_RESULT, 16'h7fff); // clamps high
      $display("test results done");
      for (int i = 0; i < 9; i++) begin
         wr_reg(ADDR_CONVERTER_CONFIG, cs[i].cfg); // bias byte
         wr_reg(ADDR_CHARGE_ACC_HIGH, cs[i].init); // load
         val <= {32'hfff0_0123, 16'h0000, cs[i].cur};
         if (cs[i].k != 0) run(int'(cs[i].k));
         // Two passes over the three words must agree with the expectation.
         for (int p = 0; p < 6; p++)
            rd_chk(ADDR_CHARGE_ACC_HIGH + 16'(p % 3), cs[i].ex[16 * (2 - p % 3) +: 16]);
         $display("test accumulator case %0d done", i);
      end
      // A shorted-input reading of -2 must lift the reported current by 2 codes
      // once the offset filter has settled and a full window has been posted.
      val <= 64'hfff0_0123_fffe_0005;
      run(300);
      rd_chk(ADDR_CURRENT_RESULT, 16'h0007); // offset removed
      $display("test offset done");
      report_and_stop();
   end
endmodule : test_battery_measurement_accumulator
`default_nettype wire
